// *** asc_host.sv ***
`timescale 1ns/100ps
module asc_host (
  input  wire logic                        ref_clk,     // 20 MHz clock.
  input  wire logic                        rst_n,       // Reset, active low.
  input  wire logic                        req_valid,   // Request strobe.
  input  wire logic                        req_write,   // 1 write, 0 read.
  input  wire logic [asc_pkg::ADDR_W-1:0]  req_addr,    // Word address.
  input  wire logic [asc_pkg::DATA_W-1:0]  req_wdata,   // Write data.
  output logic                             req_ready,   // Idle, may accept.
  output logic                             rsp_valid,   // Read data pulse.
  output logic      [asc_pkg::DATA_W-1:0]  rsp_rdata,   // Read data.
  output logic      [asc_pkg::ADDR_W-1:0]  word_address, // Memory address.
  output logic                             chip_select_n, // Select.
  output logic                             write_strobe_n, // Write strobe.
  output logic                             output_drive_enable_n, // OE.
  input  wire logic [asc_pkg::DATA_W-1:0]  data_io_i,   // Data pin in.
  output logic      [asc_pkg::DATA_W-1:0]  data_io_o,   // Data pin out.
  output logic                             data_io_oe   // High: host drives.
);

  typedef enum logic [2:0] {
    ASC_IDLE, ASC_RD_WAIT, ASC_RD_SYNC, ASC_RD_DONE,
    ASC_WR_PULSE, ASC_WR_END, ASC_GAP
  } asc_state_t;

  // One register holds the whole controller state.
  typedef struct packed {
    asc_state_t                    state;
    logic [asc_pkg::CNT_W-1:0]     cnt;
    logic                          ready;
    logic                          rvalid;
    logic [asc_pkg::DATA_W-1:0]    rdata;
    logic [asc_pkg::ADDR_W-1:0]    addr;
    logic                          cs_n;
    logic                          we_n;
    logic                          oe_n;
    logic [asc_pkg::DATA_W-1:0]    dout;
    logic                          doe;
  } asc_regs_t;

  localparam logic [asc_pkg::CNT_W-1:0] READ_WAIT =
    asc_pkg::CNT_W'(asc_pkg::READ_WAIT_CYC);
  localparam logic [asc_pkg::CNT_W-1:0] WRITE_LOW =
    asc_pkg::CNT_W'(asc_pkg::WRITE_LOW_CYC);
  localparam logic [asc_pkg::CNT_W-1:0] RELEASE =
    asc_pkg::CNT_W'(asc_pkg::RELEASE_CYC);
  localparam logic [asc_pkg::CNT_W-1:0] SYNC_WAIT =
    asc_pkg::CNT_W'(asc_pkg::SYNC_CYC);
  localparam logic [asc_pkg::CNT_W-1:0] CNT_ONE = 4'h1;

  // True on the last cycle of a timed step.
  function automatic logic step_done(input logic [asc_pkg::CNT_W-1:0] c);
    return (c <= CNT_ONE);
  endfunction

  asc_regs_t                   st_reg;
  asc_regs_t                   st_next;
  logic [asc_pkg::DATA_W-1:0]  din_sync;

  // Data pins come from outside the clock domain and cross two flops.
  asc_sync #(
    .W (asc_pkg::DATA_W)
  ) u_sync (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .d       (data_io_i),
    .q       (din_sync)
  );

  // Each timed step counts down and leaves on its last cycle.
  always_comb
  begin
    st_next        = st_reg;
    st_next.rvalid = 1'b0;
    if (st_reg.cnt != '0)
    begin
      st_next.cnt = st_reg.cnt - CNT_ONE;
    end
    case (st_reg.state)
      ASC_IDLE:
      begin
        if (req_valid)
        begin
          st_next.ready = 1'b0;
          st_next.addr  = req_addr;
          st_next.cs_n  = 1'b0;
          if (req_write)
          begin
            // Strobe and select fall together with data driven at once.
            st_next.we_n  = 1'b0;
            st_next.oe_n  = 1'b1;
            st_next.dout  = req_wdata;
            st_next.doe   = 1'b1;
            st_next.cnt   = WRITE_LOW;
            st_next.state = ASC_WR_PULSE;
          end
          else
          begin
            st_next.we_n  = 1'b1;
            st_next.oe_n  = 1'b0;
            st_next.doe   = 1'b0;
            st_next.cnt   = READ_WAIT;
            st_next.state = ASC_RD_WAIT;
          end
        end
      end
      ASC_RD_WAIT:
      begin
        if (step_done(st_reg.cnt))
        begin
          // Two more edges let the pins cross the synchroniser.
          st_next.cnt   = SYNC_WAIT;
          st_next.state = ASC_RD_SYNC;
        end
      end
      ASC_RD_SYNC:
      begin
        if (step_done(st_reg.cnt))
        begin
          st_next.state = ASC_RD_DONE;
        end
      end
      ASC_RD_DONE:
      begin
        // Address is held until data is captured.
        st_next.rdata  = din_sync;
        st_next.rvalid = 1'b1;
        st_next.cs_n   = 1'b1;
        st_next.oe_n   = 1'b1;
        st_next.cnt    = RELEASE;
        st_next.state  = ASC_GAP;
      end
      ASC_WR_PULSE:
      begin
        if (step_done(st_reg.cnt))
        begin
          // Strobe and select rise together; address and data stay.
          st_next.we_n  = 1'b1;
          st_next.cs_n  = 1'b1;
          st_next.state = ASC_WR_END;
        end
      end
      ASC_WR_END:
      begin
        st_next.doe   = 1'b0;
        st_next.cnt   = RELEASE;
        st_next.state = ASC_GAP;
      end
      ASC_GAP:
      begin
        if (step_done(st_reg.cnt))
        begin
          st_next.ready = 1'b1;
          st_next.state = ASC_IDLE;
        end
      end
      default:
      begin
        st_next.state = ASC_IDLE;
        st_next.ready = 1'b1;
        st_next.cs_n  = 1'b1;
        st_next.we_n  = 1'b1;
        st_next.oe_n  = 1'b1;
        st_next.doe   = 1'b0;
      end
    endcase
  end

  // Reset leaves the memory deselected and the data pins undriven.
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_reg.state  <= ASC_IDLE;
      st_reg.cnt    <= '0;
      st_reg.ready  <= 1'b1;
      st_reg.rvalid <= 1'b0;
      st_reg.rdata  <= asc_pkg::DATA_RST;
      st_reg.addr   <= asc_pkg::ADDR_RST;
      st_reg.cs_n   <= 1'b1;
      st_reg.we_n   <= 1'b1;
      st_reg.oe_n   <= 1'b1;
      st_reg.dout   <= asc_pkg::DATA_RST;
      st_reg.doe    <= 1'b0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // Every pin and response comes straight from the state register.
  assign req_ready             = st_reg.ready;
  assign rsp_valid             = st_reg.rvalid;
  assign rsp_rdata             = st_reg.rdata;
  assign word_address          = st_reg.addr;
  assign chip_select_n         = st_reg.cs_n;
  assign write_strobe_n        = st_reg.we_n;
  assign output_drive_enable_n = st_reg.oe_n;
  assign data_io_o             = st_reg.dout;
  assign data_io_oe            = st_reg.doe;

endmodule

// *** asc_host_properties.sv ***
`timescale 1ns/100ps
module asc_host_properties (
  input wire logic        ref_clk,               // Clock.
  input wire logic        rst_n,                 // Reset.
  input wire logic        req_valid,             // Request.
  input wire logic        req_ready,             // Idle.
  input wire logic        rsp_valid,             // Read done.
  input wire logic [15:0] word_address,          // Address.
  input wire logic        chip_select_n,         // Select.
  input wire logic        write_strobe_n,        // Strobe.
  input wire logic        output_drive_enable_n, // Memory enable.
  input wire logic [3:0]  data_io_o,             // Host data.
  input wire logic        data_io_oe             // Host drives.
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence wr_open;
    $fell(write_strobe_n) && $fell(chip_select_n) && data_io_oe;
  endsequence
  sequence wr_close;
    $rose(write_strobe_n) && $rose(chip_select_n) && data_io_oe;
  endsequence
  strobe_in_read_a: assert property (
      !output_drive_enable_n |-> write_strobe_n)
    else $error("strobe low in read");
  write_pulse_a: assert property (
      $fell(write_strobe_n) |-> wr_open ##1 wr_close)
    else $error("bad write pulse");
  write_hold_a: assert property (
      wr_open |=> $stable(data_io_o) && $stable(word_address))
    else $error("write data moved");
  addr_hold_a: assert property (
      !chip_select_n |=> $stable(word_address))
    else $error("address moved");
  read_answer_a: assert property (
      $fell(output_drive_enable_n) |->
      ##4 (rsp_valid && chip_select_n && output_drive_enable_n))
    else $error("read answer late");
  no_clash_a: assert property (
      data_io_oe |-> output_drive_enable_n)
    else $error("bus clash");
  request_take_a: assert property (
      req_valid && req_ready |=> !req_ready && !chip_select_n)
    else $error("request not taken");
  read_gap_a: assert property (rsp_valid |=> req_ready)
    else $error("no idle after read");
endmodule

bind asc_host asc_host_properties chk (.ref_clk(ref_clk), .rst_n(rst_n),
  .req_valid(req_valid), .req_ready(req_ready), .rsp_valid(rsp_valid),
  .word_address(word_address), .chip_select_n(chip_select_n),
  .write_strobe_n(write_strobe_n), .data_io_o(data_io_o),
  .output_drive_enable_n(output_drive_enable_n), .data_io_oe(data_io_oe));

// *** asc_mem_model.sv ***
`timescale 1ns/100ps
module asc_mem_model (
  input wire logic [15:0] word_address,          // Address.
  input wire logic        chip_select_n,         // Select.
  input wire logic        write_strobe_n,        // Strobe.
  input wire logic        output_drive_enable_n, // Output enable.
  input wire logic [3:0]  data_in,               // Resolved pins.
  output logic     [3:0]  data_out,              // Read data.
  output logic            data_oe                // High while driving.
);
  logic [3:0] mem [65536];
  // Stores once the pins settle, so an edge never writes a half-moved word.
  always @(word_address, chip_select_n, write_strobe_n, data_in)
  begin
    #1;
    if (!chip_select_n && !write_strobe_n)
      mem[word_address] = data_in;
  end
  // Release beats turn-on, so no two drivers overlap.
  assign #(3, 2) data_oe = !chip_select_n
    && !output_drive_enable_n
    && write_strobe_n;
  assign #6 data_out = mem[word_address];
endmodule

// *** asc_pkg.sv ***
package asc_pkg;

  localparam int CLK_PERIOD_PS = 50000;

  // Timing figures in picoseconds, for the slower speed grade.
  localparam int READ_CYCLE_PS    = 7000;
  localparam int ACCESS_PS        = 7000;
  localparam int OE_ACCESS_PS     = 4000;
  localparam int WRITE_CYCLE_PS   = 7000;
  localparam int ADDR_TO_END_PS   = 7000;
  localparam int DATA_SETUP_PS    = 3500;
  localparam int RELEASE_PS       = 3500;
  localparam int TURN_ON_PS       = 3000;

  function automatic int cyc_min(input int ps);
    int c;
    c = (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int READ_WAIT_CYC  = cyc_min(ACCESS_PS);
  localparam int WRITE_LOW_CYC  = cyc_min(ADDR_TO_END_PS);
  localparam int RELEASE_CYC    = cyc_min(RELEASE_PS);
  localparam int SYNC_CYC       = 2;

  localparam int ADDR_W = 16;
  localparam int DATA_W = 4;
  localparam int CNT_W  = 4;

  localparam logic [ADDR_W-1:0] ADDR_RST = 16'h0000;
  localparam logic [DATA_W-1:0] DATA_RST = 4'h0;

endpackage

// *** asc_sync.sv ***
`timescale 1ns/100ps
// Two-stage synchroniser for the data pins read back from the memory.
module asc_sync #(
  parameter int W = 4
) (
  input  wire logic         ref_clk,  // System clock.
  input  wire logic         rst_n,    // Asynchronous reset, active low.
  input  wire logic [W-1:0] d,        // Asynchronous input.
  output logic      [W-1:0] q         // Synchronised output.
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } asc_sync_regs_t;

  asc_sync_regs_t st_reg;
  asc_sync_regs_t st_next;

  // Logic reads only the second stage, never a metastable first one.
  always_comb
  begin
    st_next.meta = d;
    st_next.sync = st_reg.meta;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign q = st_reg.sync;

endmodule

// *** tb_async_sram_4bit_port.sv ***
`timescale 1ns/100ps
module tb_async_sram_4bit_port;
  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        req_valid = 1'b0;
  logic        req_write = 1'b0;
  logic [15:0] req_addr = 16'h0000;
  logic [3:0]  req_wdata = 4'h0;
  logic        req_ready, rsp_valid, cs_n, we_n, oe_n, host_oe, mem_oe;
  logic [3:0]  rsp_rdata, host_d, mem_d, bus;
  logic [3:0]  float_d = 4'h5;
  logic [15:0] addr;
  logic [3:0]  shadow [65536];
  bit          known [65536];
  int          fail_count = 0;
  int          compares = 0;

  always #25 ref_clk = ~ref_clk;
  always @(posedge ref_clk) float_d <= float_d + 4'h7;
  assign bus = host_oe ? host_d : (mem_oe ? mem_d : float_d);

  asc_host dut (.ref_clk(ref_clk), .rst_n(rst_n), .req_valid(req_valid),
    .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .word_address(addr), .chip_select_n(cs_n), .write_strobe_n(we_n),
    .output_drive_enable_n(oe_n), .data_io_i(bus), .data_io_o(host_d),
    .data_io_oe(host_oe));
  asc_mem_model mem (.word_address(addr), .chip_select_n(cs_n),
    .write_strobe_n(we_n), .output_drive_enable_n(oe_n), .data_in(bus),
    .data_out(mem_d), .data_oe(mem_oe));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [3:0] expect_rd(input logic [15:0] a);
    return shadow[a];
  endfunction

  task automatic tally_and_finish;
    if (fail_count == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic access(input logic w, input logic [15:0] a,
                        input logic [3:0] d);
    int n;
    n = 0;
    while (req_ready !== 1'b1 && n < 20)
    begin
      @(negedge ref_clk);
      n++;
    end
    req_valid = 1'b1;
    req_write = w;
    req_addr = a;
    req_wdata = d;
    @(negedge ref_clk);
    req_valid = 1'b0;
    if (w)
    begin
      shadow[a] = d;
      known[a] = 1'b1;
    end
    else
    begin
      repeat (4) @(negedge ref_clk);
      chk({15'h0000, rsp_valid}, 16'h0001);
      chk({12'h000, rsp_rdata}, {12'h000, expect_rd(a)});
    end
  endtask

  initial
  begin
    #150000;
    fail_count++;
    tally_and_finish();
  end

  initial
  begin
    logic [15:0] a;
    void'($urandom(99));
    repeat (2) @(negedge ref_clk);
    chk({12'h000, cs_n, we_n, oe_n, host_oe}, 16'h000E);
    rst_n = 1'b1;
    for (int i = 0; i < 16; i++)
      access(1'b1, 16'h1111 * i[15:0], i[3:0]);
    access(1'b1, 16'h0000, 4'hA);
    for (int i = 0; i < 16; i++)
      access(1'b0, 16'h1111 * i[15:0], 4'h0);
    for (int i = 0; i < 60; i++)
    begin
      a = 16'($urandom_range(0, 31));
      access($urandom_range(0, 1) == 0 || !known[a], a,
             4'($urandom()));
    end
    tally_and_finish();
  end
endmodule
